/* File: fesl_pkg.sv */
package fesl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_FILL_STATUS = 8'h00;
    localparam logic [7:0] OFS_FILL_ADDR   = 8'h04;
    localparam logic [7:0] OFS_BUS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_XLATE_STAT  = 8'h0C;
    localparam logic [7:0] OFS_CACHE_CTRL  = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;
    // fill_error_status fields
    localparam int FS_LOCK    = 0;
    localparam int FS_RDE     = 1;
    localparam int FS_TMO     = 2;
    localparam int FS_LOST    = 3;
    localparam int FS_WRITE   = 4;
    localparam int FS_OWNERSHIP_READ   = 5;
    localparam int FS_RQDONE  = 6;
    localparam int FS_COUNT   = 7;
    localparam int COUNT_W    = 2;
    localparam logic [1:0] COUNT_IO = 2'h3;
    // bus_interface_error_status fields
    localparam int BS_NOACK   = 0;
    localparam int BS_LOSTOE  = 1;
    // translation_status fields
    localparam int TS_PTE     = 0;
    localparam int TS_PTEWR   = 1;
    // cache_control fields
    localparam int CC_ETM     = 0;
    // Interrupt status and mask fields
    localparam int IRQ_W      = 4;
    localparam int IQ_HARD    = 0;
    localparam int IQ_FILL    = 1;
    localparam int IQ_REFUSE  = 2;
    localparam int IQ_PTE     = 3;
    // Reset values
    localparam logic [31:0]      RST_ADDR = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] RST_MASK = 4'h0;
    localparam logic [IRQ_W-1:0] RST_IST  = 4'h0;
endpackage : fesl_pkg

/* File: fesl_logger.sv */
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module fesl_logger (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Fill error reports from the cache controller
    input  wire logic        fill_err_i,
    input  wire logic        fill_timeout_i,
    input  wire logic        fill_write_i,
    input  wire logic        fill_ownership_read_i,
    input  wire logic        fill_mbox_write_i,
    input  wire logic        fill_pte_i,
    input  wire logic        pte_ref_write_i,
    input  wire logic [1:0]  fill_count_i,
    input  wire logic        fill_req_done_i,
    input  wire logic        fill_io_i,
    input  wire logic [31:0] fill_addr_i,
    // Bridge refusals and lock traffic
    input  wire logic        refuse_i,
    input  wire logic        refuse_write_i,
    input  wire logic        bad_write_data_i,
    input  wire logic        lock_ownership_read_i,
    input  wire logic        unlock_write_i,
    // Actions towards the cache controller
    output logic             disown_write_o,
    output logic             mbox_write_send_o,
    output logic             tag_invalidate_o,
    output logic [31:0]      invalidate_addr_o,
    output logic             machine_check_o,
    output logic             tb_miss_abort_o,
    output logic             write_discard_o,
    output logic             error_transition_mode_o,
    output logic             irq_o
);

    typedef struct packed {
        logic [8:0]                   fsts;
        logic [31:0]                  faddr;
        logic [1:0]                   bsts;
        logic [1:0]                   xsts;
        logic                         etm;
        logic [fesl_pkg::IRQ_W-1:0]   ist;
        logic [fesl_pkg::IRQ_W-1:0]   imask;
        logic                         lock_pend;
        logic                         rd_done;
        logic [31:0]                  prdata;
        logic                         disown;
        logic                         wsend;
        logic                         inval;
        logic [31:0]                  inval_addr;
        logic                         mchk;
        logic                         abort;
        logic                         discard;
    } fesl_state_t;

    fesl_state_t st_reg;
    fesl_state_t st_next;

    logic        access;
    logic        wr_hit;
    logic        mapped;
    logic [31:0] rd_mux;
    logic [31:0] w1c;
    logic [1:0]  cnt;
    logic        locked;

    always_comb begin
        mapped = 1'b1;
        case (paddr_i)
            fesl_pkg::OFS_FILL_STATUS: rd_mux = {23'h0, st_reg.fsts};
            fesl_pkg::OFS_FILL_ADDR:   rd_mux = st_reg.faddr;
            fesl_pkg::OFS_BUS_STATUS:  rd_mux = {30'h0, st_reg.bsts};
            fesl_pkg::OFS_XLATE_STAT:  rd_mux = {30'h0, st_reg.xsts};
            fesl_pkg::OFS_CACHE_CTRL:  rd_mux = {31'h0, st_reg.etm};
            fesl_pkg::OFS_IRQ_STATUS:  rd_mux = {28'h0, st_reg.ist};
            fesl_pkg::OFS_IRQ_MASK:    rd_mux = {28'h0, st_reg.imask};
            default: begin
                rd_mux = 32'h0000_0000;
                mapped = 1'b0;
            end
        endcase
    end

    assign access    = psel_i && penable_i;
    assign pready_o  = st_reg.rd_done;
    assign pslverr_o = access && st_reg.rd_done && !mapped;
    assign wr_hit    = access && st_reg.rd_done && pwrite_i && mapped;
    assign w1c       = pwdata_i;
    assign locked    = st_reg.fsts[fesl_pkg::FS_LOCK];
    // I/O space fills always report the full count
    assign cnt       = fill_io_i ? fesl_pkg::COUNT_IO : fill_count_i;

    always_comb begin
        st_next = st_reg;
        st_next.disown  = 1'b0;
        st_next.wsend   = 1'b0;
        st_next.inval   = 1'b0;
        st_next.mchk    = 1'b0;
        st_next.abort   = 1'b0;
        st_next.discard = 1'b0;

        // One wait state lets read data come from a flop
        if (access && !st_reg.rd_done) begin
            st_next.rd_done = 1'b1;
            st_next.prdata  = rd_mux;
        end else begin
            st_next.rd_done = 1'b0;
        end

        // Software clears come first so that hardware sets win
        if (wr_hit) begin
            case (paddr_i)
                fesl_pkg::OFS_FILL_STATUS: begin
                    st_next.fsts[3:0] = st_reg.fsts[3:0] & ~w1c[3:0];
                end
                fesl_pkg::OFS_BUS_STATUS: begin
                    st_next.bsts = st_reg.bsts & ~w1c[1:0];
                end
                fesl_pkg::OFS_XLATE_STAT: begin
                    st_next.xsts = st_reg.xsts & ~w1c[1:0];
                end
                fesl_pkg::OFS_CACHE_CTRL: begin
                    st_next.etm = st_reg.etm & ~w1c[0];
                end
                fesl_pkg::OFS_IRQ_STATUS: begin
                    st_next.ist = st_reg.ist & ~w1c[fesl_pkg::IRQ_W-1:0];
                end
                fesl_pkg::OFS_IRQ_MASK: begin
                    st_next.imask = w1c[fesl_pkg::IRQ_W-1:0];
                end
                default: begin
                    st_next.imask = st_reg.imask;
                end
            endcase
        end

        // Read-lock tracking for the disown write
        if (lock_ownership_read_i) begin
            st_next.lock_pend = 1'b1;
        end
        if (unlock_write_i && st_reg.lock_pend) begin
            st_next.disown    = 1'b1;
            st_next.lock_pend = 1'b0;
        end

        if (fill_err_i) begin
            if (locked) begin
                st_next.fsts[fesl_pkg::FS_LOST] = 1'b1;
                if (fill_write_i) begin
                    st_next.ist[fesl_pkg::IQ_HARD] = 1'b1;
                end
            end else begin
                st_next.fsts[fesl_pkg::FS_LOCK]   = 1'b1;
                st_next.fsts[fesl_pkg::FS_RDE]    = !fill_timeout_i;
                st_next.fsts[fesl_pkg::FS_TMO]    = fill_timeout_i;
                st_next.fsts[fesl_pkg::FS_WRITE]  = fill_write_i;
                st_next.fsts[fesl_pkg::FS_OWNERSHIP_READ]  = fill_ownership_read_i;
                st_next.fsts[fesl_pkg::FS_RQDONE] = fill_req_done_i;
                st_next.fsts[fesl_pkg::FS_COUNT +: fesl_pkg::COUNT_W] = cnt;
                st_next.faddr = fill_addr_i;
            end
            st_next.ist[fesl_pkg::IQ_FILL] = 1'b1;
            if (fill_ownership_read_i) begin
                st_next.etm        = 1'b1;
                st_next.inval      = 1'b1;
                st_next.inval_addr = fill_addr_i;
            end
            if (!fill_req_done_i) begin
                st_next.mchk = 1'b1;
            end
            if (fill_ownership_read_i && fill_timeout_i && fill_mbox_write_i) begin
                st_next.wsend = 1'b1;
            end
            if (fill_pte_i) begin
                st_next.xsts[fesl_pkg::TS_PTE] = 1'b1;
                st_next.abort = 1'b1;
                st_next.ist[fesl_pkg::IQ_PTE] = 1'b1;
                if (pte_ref_write_i) begin
                    st_next.xsts[fesl_pkg::TS_PTEWR] = 1'b1;
                    st_next.discard = 1'b1;
                end
            end
        end

        if (refuse_i) begin
            // Every refusal is hard, writes (incl. the write after a timeout) too
            st_next.ist[fesl_pkg::IQ_HARD]   = 1'b1;
            st_next.ist[fesl_pkg::IQ_REFUSE] = 1'b1;
            if (!refuse_write_i) begin
                if (st_reg.bsts[fesl_pkg::BS_NOACK]) begin
                    st_next.bsts[fesl_pkg::BS_LOSTOE] = 1'b1;
                end else begin
                    st_next.bsts[fesl_pkg::BS_NOACK] = 1'b1;
                end
            end
        end
        if (bad_write_data_i && st_reg.bsts[fesl_pkg::BS_NOACK]) begin
            st_next.bsts[fesl_pkg::BS_LOSTOE] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '{fsts: 9'h000, faddr: fesl_pkg::RST_ADDR, bsts: 2'h0, xsts: 2'h0,
                        etm: 1'b0, ist: fesl_pkg::RST_IST, imask: fesl_pkg::RST_MASK,
                        lock_pend: 1'b0, rd_done: 1'b0, prdata: 32'h0000_0000,
                        disown: 1'b0, wsend: 1'b0, inval: 1'b0,
                        inval_addr: fesl_pkg::RST_ADDR, mchk: 1'b0, abort: 1'b0,
                        discard: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata_o                = st_reg.prdata;
    assign disown_write_o          = st_reg.disown;
    assign mbox_write_send_o       = st_reg.wsend;
    assign tag_invalidate_o        = st_reg.inval;
    assign invalidate_addr_o       = st_reg.inval_addr;
    assign machine_check_o         = st_reg.mchk;
    assign tb_miss_abort_o         = st_reg.abort;
    assign write_discard_o         = st_reg.discard;
    assign error_transition_mode_o = st_reg.etm;
    assign irq_o                   = |(st_reg.ist & st_reg.imask);

    logic [31:0] fill_err_addr_view;
    assign fill_err_addr_view = st_reg.faddr;
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_disown_issue: assert property (unlock_write_i && st_reg.lock_pend |=> disown_write_o)
        else $error("unlock after lock read gave no disown write");
    a_lost_keep: assert property (fill_err_i && locked |=> $stable(fill_err_addr_view)
        && st_reg.fsts[fesl_pkg::FS_LOST])
        else $error("locked fill report overwritten or lost flag missing");
    a_lost_write_hard: assert property (fill_err_i && locked && fill_write_i
        |=> st_reg.ist[fesl_pkg::IQ_HARD])
        else $error("lost write fill error without hard error");
    a_etm_ownership_read: assert property (fill_err_i |=> (st_reg.etm == ($past(st_reg.etm)
        || $past(fill_ownership_read_i)) || $past(wr_hit)))
        else $error("error transition mode wrong after fill error");
    a_refuse_hard: assert property (refuse_i |=> st_reg.ist[fesl_pkg::IQ_HARD])
        else $error("refused command without hard error");
    a_tag_inval: assert property (fill_err_i && fill_ownership_read_i |=> tag_invalidate_o
        ##1 !tag_invalidate_o || fill_ownership_read_i)
        else $error("ownership read fill error did not invalidate block");
    a_mchk_req: assert property (fill_err_i |=> machine_check_o == !$past(fill_req_done_i))
        else $error("machine check does not follow requested quadword status");
    a_pte_abort: assert property (fill_err_i && fill_pte_i |=> tb_miss_abort_o
        && st_reg.xsts[fesl_pkg::TS_PTE])
        else $error("page table read error not flagged or miss not aborted");
    a_pte_write: assert property (fill_err_i && fill_pte_i && pte_ref_write_i
        |=> write_discard_o && st_reg.xsts[fesl_pkg::TS_PTEWR])
        else $error("page table write error not flagged");
    a_io_count: assert property (fill_err_i && !locked && fill_io_i
        |=> st_reg.fsts[8:7] == fesl_pkg::COUNT_IO)
        else $error("I/O space fill count not binary 11");
    a_mbox_send: assert property (fill_err_i && fill_ownership_read_i && fill_timeout_i
        && fill_mbox_write_i |=> mbox_write_send_o)
        else $error("write after ownership read timeout not sent");
    a_lost_output_error_flag: assert property (refuse_i && !refuse_write_i
        && st_reg.bsts[fesl_pkg::BS_NOACK] |=> st_reg.bsts[fesl_pkg::BS_LOSTOE])
        else $error("missed refusal did not set lost output flag");
    a_sticky: assert property (st_reg.fsts[fesl_pkg::FS_LOST] && !wr_hit
        |=> st_reg.fsts[fesl_pkg::FS_LOST])
        else $error("lost fill flag dropped without software write");

    c_lost_fill: cover property (fill_err_i && locked);
    c_pte_write: cover property (fill_err_i && fill_pte_i && pte_ref_write_i);
    c_disown:    cover property (disown_write_o);
    c_irq:       cover property (irq_o ##1 !irq_o);

endmodule : fesl_logger

/* File: fesl_bridge_model.sv */
`timescale 1ns/1ps
module fesl_bridge_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Command from the cache side
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_write_i,
    input  wire logic [31:0] cmd_addr_i,
    input  wire logic        cmd_parity_ok_i,
    input  wire logic        queue_full_i,
    // Answer and own status
    output logic             refuse_o,
    output logic             refuse_write_o,
    output logic             parity_flag_o,
    output logic             qfull_flag_o,
    output logic [31:0]      refused_addr_o,
    output logic             refused_cmd_o
);
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            refuse_o       <= 1'b0;
            refuse_write_o <= 1'b0;
            parity_flag_o  <= 1'b0;
            qfull_flag_o   <= 1'b0;
            refused_addr_o <= 32'h0000_0000;
            refused_cmd_o  <= 1'b0;
        end else begin
            // A command with good parity and a free queue is acknowledged whatever its address
            refuse_o       <= cmd_valid_i && (!cmd_parity_ok_i || queue_full_i);
            refuse_write_o <= cmd_valid_i && cmd_write_i;
            if (cmd_valid_i && !cmd_parity_ok_i) begin
                parity_flag_o  <= 1'b1;
                // Keep the command refused for bad parity and its address for software
                refused_addr_o <= cmd_addr_i;
                refused_cmd_o  <= cmd_write_i;
            end
            if (cmd_valid_i && queue_full_i) begin
                qfull_flag_o <= 1'b1;
            end
        end
    end
endmodule : fesl_bridge_model

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] FS = fesl_pkg::OFS_FILL_STATUS;
    localparam logic [7:0] BS = fesl_pkg::OFS_BUS_STATUS;
    localparam logic [7:0] TS = fesl_pkg::OFS_XLATE_STAT;
    localparam logic [7:0] CC = fesl_pkg::OFS_CACHE_CTRL;
    localparam logic [7:0] IS = fesl_pkg::OFS_IRQ_STATUS;
    localparam logic [7:0] IM = fesl_pkg::OFS_IRQ_MASK;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, irq, etm;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, fill_addr, inv_addr, cmd_addr, ref_addr;
    logic        ref_cmd;
    logic        fill_err, fill_timeout, fill_write, fill_ownership_read, fill_mbox, fill_pte, pte_wr;
    logic        req_done, fill_io, refuse, refuse_write, bad_data, lock_ownership_read, unlock_write;
    logic [1:0]  fill_count;
    logic        disown, mbox_send, tag_inv, mcheck, tb_abort, discard;
    logic        cmd_valid, cmd_write, cmd_parity_ok, queue_full, parity_flag, qfull_flag;
    logic [5:0]  acts;
    int          failures = 0;
    int          checks = 0;
    assign acts = {disown, mbox_send, tag_inv, mcheck, tb_abort, discard};

    fesl_logger fesl_logger_inst (
        .clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .fill_err_i(fill_err),
        .fill_timeout_i(fill_timeout), .fill_write_i(fill_write), .fill_ownership_read_i(fill_ownership_read),
        .fill_mbox_write_i(fill_mbox), .fill_pte_i(fill_pte), .pte_ref_write_i(pte_wr),
        .fill_count_i(fill_count), .fill_req_done_i(req_done), .fill_io_i(fill_io),
        .fill_addr_i(fill_addr), .refuse_i(refuse), .refuse_write_i(refuse_write),
        .bad_write_data_i(bad_data), .lock_ownership_read_i(lock_ownership_read), .unlock_write_i(unlock_write),
        .disown_write_o(disown), .mbox_write_send_o(mbox_send), .tag_invalidate_o(tag_inv),
        .invalidate_addr_o(inv_addr), .machine_check_o(mcheck), .tb_miss_abort_o(tb_abort),
        .write_discard_o(discard), .error_transition_mode_o(etm), .irq_o(irq));
    fesl_bridge_model fesl_bridge_model_inst (
        .clk_i(clk), .resetn_i(resetn), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
        .cmd_addr_i(cmd_addr), .cmd_parity_ok_i(cmd_parity_ok), .queue_full_i(queue_full),
        .refuse_o(refuse), .refuse_write_o(refuse_write), .parity_flag_o(parity_flag),
        .qfull_flag_o(qfull_flag), .refused_addr_o(ref_addr), .refused_cmd_o(ref_cmd));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            failures++;
            final_report();
        end
    endtask : apb

    task automatic rg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic        x;
        apb(1'b0, a, 32'h0, d, x);
        chk(d, e);
    endtask : rg

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic        x;
        apb(1'b1, a, wd, d, x);
        #1;
    endtask : wr

    // Qualifier order: pte_wr, pte, mbox, ownership_read, write, timeout, req_done, io
    task automatic fill(input logic [7:0] q, input logic [1:0] cnt, input logic [31:0] a);
        @(posedge clk);
        fill_err <= 1'b1;
        {pte_wr, fill_pte, fill_mbox, fill_ownership_read, fill_write, fill_timeout, req_done, fill_io} <= q;
        fill_count <= cnt;
        fill_addr  <= a;
        @(posedge clk);
        fill_err <= 1'b0;
        #1;
    endtask : fill

    task automatic cmd(input logic w, input logic pok, input logic qf);
        @(posedge clk);
        cmd_valid     <= 1'b1;
        cmd_write     <= w;
        cmd_addr      <= 32'h0000_6000;
        cmd_parity_ok <= pok;
        queue_full    <= qf;
        @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : cmd

    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        logic [31:0] d;
        logic        e;
        {resetn, psel, penable, pwrite, paddr, pwdata, fill_err, fill_timeout, fill_write} = '0;
        {fill_ownership_read, fill_mbox, fill_pte, pte_wr, req_done, fill_io, fill_count} = '0;
        {fill_addr, bad_data, lock_ownership_read, unlock_write} = '0;
        {cmd_valid, cmd_write, cmd_parity_ok, queue_full, cmd_addr} = '0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) rg(8'(i * 4), 32'h0);
        apb(1'b0, 8'h1C, 32'h0, d, e);
        chk({d[30:0], e}, 32'h0000_0001);
        $display("test reset done");
        fill(8'h01, 2'h0, 32'h0000_1040);
        chk(acts, 6'h04);
        chk(etm, 1'b0);
        rg(FS, 32'h0000_0183);
        fill(8'h0E, 2'h1, 32'h0000_3000);
        rg(FS, 32'h0000_018B);
        rg(fesl_pkg::OFS_FILL_ADDR, 32'h0000_1040);
        rg(IS, 32'h0000_0003);
        chk(irq, 1'b0);
        wr(IM, 32'h0000_0001);
        chk(irq, 1'b1);
        wr(IS, 32'h0000_0001);
        chk(irq, 1'b0);
        rg(IS, 32'h0000_0002);
        $display("test lost fill done");
        wr(FS, 32'h0000_000F);
        fill(8'h12, 2'h2, 32'h0000_2080);
        chk(acts, 6'h08);
        chk(inv_addr, 32'h0000_2080);
        chk(etm, 1'b1);
        rg(FS, 32'h0000_0163);
        wr(CC, 32'h0000_0001);
        wr(CC, 32'h0000_0001);
        rg(CC, 32'h0);
        wr(FS, 32'h0000_000F);
        fill(8'h36, 2'h0, 32'h0000_4000);
        chk(acts, 6'h18);
        wr(FS, 32'h0000_000F);
        fill(8'hC6, 2'h0, 32'h0000_5000);
        chk(acts, 6'h03);
        rg(TS, 32'h0000_0003);
        wr(TS, 32'h0000_0003);
        rg(TS, 32'h0);
        $display("test fill kinds done");
        wr(IS, 32'h0000_000F);
        cmd(1'b0, 1'b0, 1'b0);
        chk(parity_flag, 1'b1);
        chk(ref_addr, 32'h0000_6000);
        chk(ref_cmd, 1'b0);
        rg(BS, 32'h0000_0001);
        rg(IS, 32'h0000_0005);
        @(posedge clk);
        bad_data <= 1'b1;
        @(posedge clk);
        bad_data <= 1'b0;
        rg(BS, 32'h0000_0003);
        wr(BS, 32'h0000_0003);
        wr(IS, 32'h0000_000F);
        cmd(1'b1, 1'b1, 1'b1);
        chk(qfull_flag, 1'b1);
        rg(IS, 32'h0000_0005);
        wr(BS, 32'h0000_0003);
        cmd(1'b0, 1'b1, 1'b0);
        rg(BS, 32'h0);
        $display("test refusals done");
        @(posedge clk);
        unlock_write <= 1'b1;
        @(posedge clk);
        unlock_write <= 1'b0;
        #1 chk(acts, 6'h00);
        @(posedge clk);
        lock_ownership_read <= 1'b1;
        @(posedge clk);
        lock_ownership_read   <= 1'b0;
        unlock_write <= 1'b1;
        @(posedge clk);
        unlock_write <= 1'b0;
        #1 chk(acts, 6'h20);
        $display("test lock done");
        final_report();
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule : testbench
